//--- hdl/ssp_pkg.sv
// Package of constants and types for the serial peripheral port
package ssp_pkg;
    localparam int SSP_W = 16;
    localparam logic [3:0] SSP_BITS8 = 4'h7;
    localparam logic [3:0] SSP_BITS16 = 4'hf;
    localparam logic [3:0] SSP_MSB8 = 4'h7;
    localparam logic [3:0] SSP_MSB16 = 4'hf;
    localparam logic [15:0] SSP_WORD_RST = 16'h0000;
    localparam logic [7:0] SSP_DIV_ONE = 8'h01;
    // Primary prescale codes 0..3 give 64,16,4,1; secondary codes 0..7 give 8..1
    localparam logic [7:0] SSP_PRI_64 = 8'h40;
    localparam logic [7:0] SSP_PRI_16 = 8'h10;
    localparam logic [7:0] SSP_PRI_4 = 8'h04;
    localparam logic [7:0] SSP_PRI_1 = 8'h01;
    localparam logic [3:0] SSP_SEC_MAX = 4'h8;

    typedef struct packed {
        logic enable;
        logic master;
        logic word_width_sel;
        logic clock_idle_polarity;
        logic clock_edge_sel;
        logic select_control_enable;
        logic data_out_disable;
        logic [1:0] primary_prescale;
        logic [2:0] secondary_prescale;
    } ssp_port_control_s;

    typedef struct packed {
        logic rx_overflow;
        logic tx_full;
        logic rx_full;
    } ssp_port_status_s;

    typedef enum logic [2:0] {
        SSP_IDLE = 3'b001,
        SSP_LEAD = 3'b010,
        SSP_TRAIL = 3'b100
    } ssp_state_e;
endpackage

//--- hdl/ssp_sync.sv
// Two-stage synchroniser for one pin input
`timescale 1ns/1ps
module ssp_sync (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_d,
    output logic o_q
);
    logic meta;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= 1'b0;
            o_q <= 1'b0;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule

//--- hdl/ssp_prescaler.sv
// Two-stage prescaler giving a half-period enable pulse for the master clock
`timescale 1ns/1ps
module ssp_prescaler
    import ssp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic [1:0] i_primary_prescale,
    input wire logic [2:0] i_secondary_prescale,
    output logic o_tick
);
    logic [7:0] pri_cnt;
    logic [3:0] sec_cnt;
    logic [7:0] next_pri_cnt;
    logic [3:0] next_sec_cnt;
    logic [7:0] pri_div;
    logic [3:0] sec_div;
    logic pri_tick;

    always_comb begin
        unique case (i_primary_prescale)
            2'h0: pri_div = SSP_PRI_64;
            2'h1: pri_div = SSP_PRI_16;
            2'h2: pri_div = SSP_PRI_4;
            2'h3: pri_div = SSP_PRI_1;
        endcase
        sec_div = SSP_SEC_MAX - {1'b0, i_secondary_prescale};
        pri_tick = (pri_cnt == pri_div - SSP_DIV_ONE);
        next_pri_cnt = pri_tick ? 8'h00 : pri_cnt + 8'h01;
        next_sec_cnt = sec_cnt;
        o_tick = 1'b0;
        if (pri_tick) begin
            if (sec_cnt == sec_div - 4'h1) begin
                next_sec_cnt = 4'h0;
                o_tick = 1'b1;
            end else begin
                next_sec_cnt = sec_cnt + 4'h1;
            end
        end
        if (!i_run) begin
            next_pri_cnt = 8'h00;
            next_sec_cnt = 4'h0;
            o_tick = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pri_cnt <= 8'h00;
            sec_cnt <= 4'h0;
        end else begin
            pri_cnt <= next_pri_cnt;
            sec_cnt <= next_sec_cnt;
        end
    end
endmodule

//--- hdl/ssp_port.sv
// Serial peripheral port: shift register, double buffers, master and slave clocking
`timescale 1ns/1ps
// Contract
// RL1: One 16-bit shift register plus a software-visible data buffer.
// RL2: Link has data in, data out, shift clock and active-low select.
// RL3: Master drives shift clock; slave receives it.
// RL4: Transfers are 8 or 16 pulses, one bit out and in per pulse.
// RL5: Completion sets the done flag; interrupt only when enabled.
// RL6: Received word moves from shift register into receive buffer.
// RL7: Full receive buffer on move sets overflow and drops the word.
// RL8: Overflow freezes shifting until software reads the buffer.
// RL9: At transfer end, copy to receive buffer then load pending transmit data.
// RL10: Write goes to transmit buffer, read returns receive buffer.
// RL11: Master prescales system clock and starts on buffer write.
// RL12: Master raises done at the middle of the last bit.
// RL13: Slave shifts only on external master's clock pulses.
// RL14: Slave raises done when it latches the last bit.
// RL15: With select control, act only while select low; data out off when high.
// RL16: Input clock passes a 2-bit then a 3-bit prescaler.
// RL17: Edge select picks which clock transition launches data; the master ignores it and launches on the active-to-idle transition.
// RL18: Polarity bit sets shift clock idle level.
// RL19: Out from bit 7 or bit 15; in at bit 0.
// RL20: Changing word width resets the port.
// RL21: Select rising resets counters; next fall restarts at the top bit.
// RL22: Data-out disable stops driving serial data out.
// RL23: Prescale codes map monotonically to fixed division factors.
// RL24: Reset clears overflow, buffer flags, counter; clock idles. The master clock resets low, even with idle-high polarity.
module ssp_port
    import ssp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire ssp_pkg::ssp_port_control_s i_port_control,
    input wire logic i_port1_done_enable,
    input wire logic i_buf_wr,
    input wire logic [15:0] i_buf_wdata,
    input wire logic i_buf_rd,
    output logic [15:0] o_data_buffer,
    output ssp_pkg::ssp_port_status_s o_port_status,
    output logic o_port1_done_flag,
    input wire logic i_done_clear,
    output logic o_irq,
    input wire logic i_serial_data_in,
    output logic o_serial_data_out,
    output logic o_serial_data_out_oe_n,
    input wire logic i_shift_clock,
    output logic o_shift_clock,
    output logic o_shift_clock_oe_n,
    input wire logic i_slave_select_n
);
    import ssp_pkg::*;

    logic sdi_s;
    logic sck_s;
    logic ss_n_s;
    logic sel_s;
    logic [2:0] sync_fill;
    logic [2:0] next_sync_fill;
    logic sync_live;
    logic tick;
    logic [15:0] shift_reg;
    logic [15:0] rx_holding;
    logic [15:0] tx_holding;
    logic [3:0] bit_cnt;
    logic rx_full;
    logic tx_full;
    logic rx_overflow;
    logic done_flag;
    logic sck_out;
    logic sck_prev;
    logic ss_prev;
    logic width_prev;
    logic sdo;
    logic in_bit;
    ssp_state_e state;

    logic [15:0] next_shift_reg;
    logic [15:0] next_rx_holding;
    logic [15:0] next_tx_holding;
    logic [3:0] next_bit_cnt;
    logic next_rx_full;
    logic next_tx_full;
    logic next_rx_overflow;
    logic next_done_flag;
    logic next_sck_out;
    logic next_sdo;
    logic next_in_bit;
    ssp_state_e next_state;

    logic [3:0] last_bit;
    logic [3:0] msb_idx;
    logic active_edge;
    logic launch_edge;
    logic sample_edge;
    logic ext_rise;
    logic ext_fall;
    logic sel_ok;
    logic restart;
    logic word_done;
    logic done_set;

    ssp_sync u_sync_sdi (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_serial_data_in), .o_q(sdi_s));
    ssp_sync u_sync_sck (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_shift_clock), .o_q(sck_s));
    // Select is synchronised as active high so its reset value means deselected
    ssp_sync u_sync_ss (.i_clk(i_clk), .i_rst(i_rst), .i_d(!i_slave_select_n), .o_q(sel_s));

    // Prescaler runs only during a master word, so each word starts on a full half period
    ssp_prescaler u_pre (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_run(i_port_control.enable && i_port_control.master && state != SSP_IDLE),
        .i_primary_prescale(i_port_control.primary_prescale), // RL16 RL23
        .i_secondary_prescale(i_port_control.secondary_prescale),
        .o_tick(tick)
    );

    always_comb begin
        ss_n_s = !sel_s;
        // Pin edges count only once synchroniser and edge register hold real samples
        next_sync_fill = {sync_fill[1:0], 1'b1};
        sync_live = sync_fill[2];
        last_bit = i_port_control.word_width_sel ? SSP_BITS16 : SSP_BITS8; // RL4
        msb_idx = i_port_control.word_width_sel ? SSP_MSB16 : SSP_MSB8; // RL19
        ext_rise = sync_live && sck_s && !sck_prev;
        ext_fall = sync_live && !sck_s && sck_prev;
        // Active edge leaves idle level; trailing edge returns to it
        active_edge = i_port_control.clock_idle_polarity ? ext_fall : ext_rise; // RL18
        sel_ok = !i_port_control.select_control_enable || !ss_n_s; // RL15
        // Disable, a width change or a select release all drop the port back to idle
        restart = (i_port_control.select_control_enable && ss_n_s && !ss_prev) // RL21
            || (i_port_control.word_width_sel != width_prev) // RL20
            || !i_port_control.enable;
        // Slave: edge select 1 launches on active-to-idle, samples on idle-to-active
        if (i_port_control.clock_edge_sel) begin // RL17
            sample_edge = active_edge;
            launch_edge = i_port_control.clock_idle_polarity ? ext_rise : ext_fall;
        end else begin
            sample_edge = i_port_control.clock_idle_polarity ? ext_rise : ext_fall;
            launch_edge = active_edge;
        end
    end

    always_comb begin
        next_shift_reg = shift_reg;
        next_rx_holding = rx_holding;
        next_tx_holding = tx_holding;
        next_bit_cnt = bit_cnt;
        next_rx_full = rx_full;
        next_tx_full = tx_full;
        next_rx_overflow = rx_overflow;
        next_sck_out = sck_out;
        next_sdo = sdo;
        next_in_bit = in_bit;
        next_state = state;
        word_done = 1'b0;
        if (i_buf_wr) begin // RL10
            next_tx_holding = i_buf_wdata;
            next_tx_full = 1'b1;
        end
        if (i_buf_rd) begin
            next_rx_full = 1'b0;
            next_rx_overflow = 1'b0; // RL8
        end
        if (restart) begin
            next_bit_cnt = 4'h0;
            next_state = SSP_IDLE;
            next_sck_out = i_port_control.clock_idle_polarity; // RL18
            if (!i_port_control.enable) begin
                next_rx_full = 1'b0;
                next_tx_full = i_buf_wr;
                next_rx_overflow = 1'b0;
            end
        end else if (rx_overflow) begin
            // A master frozen here holds its clock level until the buffer is read
            next_state = state; // RL8
        end else if (i_port_control.master) begin // RL3 RL11
            unique case (state)
                SSP_IDLE: begin
                    next_sck_out = i_port_control.clock_idle_polarity;
                    if (tx_full) begin
                        next_shift_reg = tx_holding;
                        next_tx_full = i_buf_wr;
                        next_bit_cnt = 4'h0;
                        next_sdo = tx_holding[msb_idx]; // RL19
                        next_state = SSP_LEAD;
                    end
                end
                SSP_LEAD: if (tick) begin
                    next_sck_out = !i_port_control.clock_idle_polarity;
                    next_in_bit = sdi_s; // RL4
                    next_state = SSP_TRAIL;
                    word_done = (bit_cnt == last_bit); // RL12
                end
                SSP_TRAIL: if (tick) begin
                    next_sck_out = i_port_control.clock_idle_polarity;
                    next_shift_reg = {shift_reg[14:0], in_bit}; // RL19
                    next_sdo = shift_reg[msb_idx - 4'h1];
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == last_bit) begin
                        next_state = SSP_IDLE;
                    end else begin
                        next_state = SSP_LEAD;
                    end
                end
                default: next_state = SSP_IDLE;
            endcase
        end else if (sel_ok) begin // RL13 RL3
            // Pin edges arrive two cycles late; data in is delayed alike
            if (sample_edge) begin
                next_shift_reg = {shift_reg[14:0], sdi_s}; // RL4 RL19
                next_bit_cnt = bit_cnt + 4'h1;
                if (bit_cnt == last_bit) begin
                    word_done = 1'b1; // RL14
                    next_bit_cnt = 4'h0;
                end
            end
            if (state == SSP_IDLE && tx_full) begin
                // A write made before the frame is the first word sent
                next_shift_reg = tx_holding; // RL9
                next_tx_full = i_buf_wr;
                next_sdo = tx_holding[msb_idx]; // RL19
                next_state = SSP_LEAD;
            end else if (launch_edge || state == SSP_IDLE) begin
                next_sdo = shift_reg[msb_idx];
                next_state = SSP_LEAD;
            end
        end
        // Word complete: receive copy, overflow check, slave reloads transmit
        if (word_done && !restart) begin
            if (rx_full && !i_buf_rd) begin
                next_rx_overflow = 1'b1; // RL7
            end else begin
                // Master takes its last bit from the pin; the shift is still half a bit away
                next_rx_holding = i_port_control.master ? {shift_reg[14:0], sdi_s}
                    : next_shift_reg; // RL6 RL9
                next_rx_full = 1'b1;
            end
            if (!i_port_control.master && (tx_full || i_buf_wr)) begin
                next_shift_reg = i_buf_wr ? i_buf_wdata : tx_holding; // RL9
                next_tx_full = 1'b0;
                next_state = SSP_IDLE;
            end
        end
        // A clear in the same cycle as a new completion loses
        done_set = word_done && !restart;
        next_done_flag = done_set || (done_flag && !i_done_clear); // RL5
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin // RL24
            shift_reg <= SSP_WORD_RST;
            rx_holding <= SSP_WORD_RST;
            tx_holding <= SSP_WORD_RST;
            bit_cnt <= 4'h0;
            rx_full <= 1'b0;
            tx_full <= 1'b0;
            rx_overflow <= 1'b0;
            done_flag <= 1'b0;
            sck_out <= 1'b0;
            sck_prev <= 1'b0;
            ss_prev <= 1'b1;
            width_prev <= 1'b0;
            sdo <= 1'b0;
            in_bit <= 1'b0;
            state <= SSP_IDLE;
            sync_fill <= 3'h0;
        end else begin
            shift_reg <= next_shift_reg;
            rx_holding <= next_rx_holding;
            tx_holding <= next_tx_holding;
            bit_cnt <= next_bit_cnt;
            rx_full <= next_rx_full;
            tx_full <= next_tx_full;
            rx_overflow <= next_rx_overflow;
            done_flag <= next_done_flag;
            sck_out <= next_sck_out;
            sck_prev <= sck_s;
            ss_prev <= ss_n_s;
            width_prev <= i_port_control.word_width_sel;
            sdo <= next_sdo;
            in_bit <= next_in_bit;
            state <= next_state;
            sync_fill <= next_sync_fill;
        end
    end

    always_comb begin
        o_data_buffer = rx_holding; // RL10 RL1
        o_port_status = '{rx_overflow: rx_overflow, tx_full: tx_full, rx_full: rx_full};
        o_port1_done_flag = done_flag;
        o_irq = done_flag && i_port1_done_enable; // RL5
        o_serial_data_out = sdo;
        // Reset idle level follows polarity once control settles
        o_shift_clock = (i_port_control.master && i_port_control.enable) ? sck_out
            : i_port_control.clock_idle_polarity; // RL18 RL24
        o_shift_clock_oe_n = !(i_port_control.master && i_port_control.enable); // RL3
        // Data out floats when disabled, suppressed or deselected
        o_serial_data_out_oe_n = !i_port_control.enable
            || i_port_control.data_out_disable // RL22
            || (!i_port_control.master && i_port_control.select_control_enable
                && ss_n_s); // RL15 RL2
    end
endmodule

//--- sim/ssp_port_monitor.sv
// Concurrent checks on the serial peripheral port pins and status
`timescale 1ns/1ps
module ssp_port_monitor
    import ssp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire ssp_pkg::ssp_port_control_s i_port_control,
    input wire logic i_port1_done_enable,
    input wire logic i_buf_rd,
    input wire logic i_slave_select_n,
    input wire logic [15:0] o_data_buffer,
    input wire ssp_pkg::ssp_port_status_s o_port_status,
    input wire logic o_port1_done_flag,
    input wire logic o_irq,
    input wire logic o_serial_data_out_oe_n,
    input wire logic o_shift_clock,
    input wire logic o_shift_clock_oe_n
);
    ssp_port_control_s ctl_q;
    ssp_port_control_s next_ctl_q;
    logic held;
    logic next_held;
    logic steady;
    always_comb begin
        next_ctl_q = i_port_control;
        next_held = (i_port_control == ctl_q);
    end
    always_ff @(posedge i_clk) begin
        ctl_q <= next_ctl_q;
        held <= next_held;
    end
    // Control unchanged over the last three samples
    assign steady = held && (i_port_control == ctl_q);
    default clocking mon_cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence master_on;
        steady && i_port_control.master && i_port_control.enable;
    endsequence
    sequence select_high;
        (steady && i_port_control.select_control_enable && !i_port_control.master
            && i_slave_select_n) [*5];
    endsequence
    sequence overflow_wait;
        steady && i_port_control.enable && o_port_status.rx_overflow && !i_buf_rd;
    endsequence
    irq_gate_a: assert property (o_irq == (o_port1_done_flag && i_port1_done_enable))
        else $error("irq does not follow flag and enable");
    clk_drive_a: assert property (steady |->
        o_shift_clock_oe_n == !(i_port_control.master && i_port_control.enable))
        else $error("shift clock drive wrong");
    sdo_off_a: assert property (steady && i_port_control.data_out_disable |->
        o_serial_data_out_oe_n) else $error("data out driven while disabled");
    sel_off_a: assert property (select_high |-> o_serial_data_out_oe_n)
        else $error("data out driven while deselected");
    slave_idle_a: assert property (steady && !i_port_control.master |->
        o_shift_clock == i_port_control.clock_idle_polarity) else $error("clock not idle");
    reset_clear_a: assert property ($fell(i_rst) |-> o_port_status == 3'h0
        && !o_port1_done_flag) else $error("flags not clear after reset");
    ovf_hold_a: assert property (overflow_wait |=> o_port_status.rx_overflow)
        else $error("overflow dropped without read");
    ovf_keep_a: assert property (overflow_wait |=> $stable(o_data_buffer))
        else $error("buffer changed during overflow");
    done_rx_a: assert property ($rose(o_port_status.rx_full) |-> ##[0:2] o_port1_done_flag)
        else $error("receive without done flag");
    sck_rate_a: assert property (master_on ##0 (i_port_control.primary_prescale == 2'h3
        && i_port_control.secondary_prescale == 3'h4 && $changed(o_shift_clock)
        && o_shift_clock != i_port_control.clock_idle_polarity) |=> $stable(o_shift_clock) [*3])
        else $error("shift clock half period short");
endmodule
bind ssp_port ssp_port_monitor ssp_port_monitor_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_port_control(i_port_control),
    .i_port1_done_enable(i_port1_done_enable), .i_buf_rd(i_buf_rd),
    .i_slave_select_n(i_slave_select_n), .o_data_buffer(o_data_buffer),
    .o_port_status(o_port_status), .o_port1_done_flag(o_port1_done_flag), .o_irq(o_irq),
    .o_serial_data_out_oe_n(o_serial_data_out_oe_n), .o_shift_clock(o_shift_clock),
    .o_shift_clock_oe_n(o_shift_clock_oe_n)
);

//--- sim/ssp_link_model.sv
// Far-side serial device: slave to the port as master, master to it as slave
`timescale 1ns/1ps
module ssp_link_model (
    input wire logic i_clk,
    input wire logic i_sck,
    input wire logic i_sdo,
    input wire logic i_sdo_oe_n,
    input wire logic i_pol,
    output logic o_sdi,
    output logic o_sck,
    output logic o_ss_n
);
    logic [31:0] tx_word = 32'h0;
    logic [31:0] rx_word = 32'h0;
    logic pulse = 1'b0;
    initial o_ss_n = 1'b1;
    assign o_sck = i_pol ^ pulse;
    assign o_sdi = tx_word[31];
    // Leaving idle samples, returning to idle launches; a released line reads inverted
    always @(i_sck) begin
        if (i_sck !== i_pol) begin
            rx_word = {rx_word[30:0], i_sdo_oe_n ? ~rx_word[0] : i_sdo};
        end else begin
            tx_word = {tx_word[30:0], ~tx_word[0]};
        end
    end
    task automatic frame(input int n, input int half);
        @(posedge i_clk) o_ss_n <= 1'b0;
        repeat (half) @(posedge i_clk);
        repeat (n) begin
            pulse <= 1'b1;
            repeat (half) @(posedge i_clk);
            pulse <= 1'b0;
            repeat (half) @(posedge i_clk);
        end
        o_ss_n <= 1'b1;
        repeat (half) @(posedge i_clk);
        #1;
    endtask
endmodule

//--- sim/test_ssp_port.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/1ps
module test_ssp_port;
    import ssp_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    ssp_port_control_s ctl = 12'h100;
    logic done_en = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic clr = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rbuf;
    ssp_port_status_s stat;
    logic done, irq, sdi, sdo, sdo_oe_n, sck_out, sck_oe_n, m_sck, ss_n, sck;
    int error_cnt = 0;
    int comparisons = 0;
    int pulses = 0;
    int half = 0;
    assign sck = ctl.master ? sck_out : m_sck;
    ssp_port ssp_port_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_port_control(ctl), .i_port1_done_enable(done_en),
        .i_buf_wr(wr), .i_buf_wdata(wdata), .i_buf_rd(rd), .o_data_buffer(rbuf),
        .o_port_status(stat), .o_port1_done_flag(done), .i_done_clear(clr), .o_irq(irq),
        .i_serial_data_in(sdi), .o_serial_data_out(sdo), .o_serial_data_out_oe_n(sdo_oe_n),
        .i_shift_clock(sck), .o_shift_clock(sck_out), .o_shift_clock_oe_n(sck_oe_n),
        .i_slave_select_n(ss_n)
    );
    ssp_link_model ssp_link_model_inst (
        .i_clk(i_clk), .i_sck(sck), .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n),
        .i_pol(ctl.clock_idle_polarity), .o_sdi(sdi), .o_sck(m_sck), .o_ss_n(ss_n)
    );
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge sck) pulses++;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cfg(input logic [11:0] c);
        @(posedge i_clk) ctl <= c;
        repeat (4) @(posedge i_clk);
    endtask
    task automatic wr_buf(input logic [15:0] d);
        @(posedge i_clk) begin
            wr <= 1'b1;
            wdata <= d;
        end
        @(posedge i_clk) wr <= 1'b0;
    endtask
    task automatic rd_buf(input string what, input logic [15:0] exp, input logic [15:0] mask);
        #1;
        chk(what, rbuf & mask, exp);
        @(posedge i_clk) rd <= 1'b1;
        @(posedge i_clk) rd <= 1'b0;
    endtask
    task automatic clr_done();
        @(posedge i_clk) clr <= 1'b1;
        @(posedge i_clk) clr <= 1'b0;
    endtask
    // Bounded wait on the done flag or on overflow
    task automatic wait_sig(input bit ovf);
        int n;
        n = 0;
        while (((ovf ? stat.rx_overflow : done) !== 1'b1) && n < 2000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 2000) begin
            error_cnt++;
            $display("ERROR wait limit expected event seen timeout");
        end
    endtask
    // Cycles until the shift clock is back at its idle level
    task automatic idle_wait(output int n);
        n = 0;
        while (sck_out !== ctl.clock_idle_polarity && n < 100) begin
            @(posedge i_clk);
            #1;
            n++;
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        chk("status", stat, 3'h0);
        chk("done flag", done, 1'b0);
        chk("idle clock", sck_out, 1'b1);
        $display("test reset finished");
        cfg(12'hc9c);
        ssp_link_model_inst.tx_word = 32'ha5000000;
        pulses = 0;
        wr_buf(16'h003c);
        wait_sig(1'b0);
        chk("clock at last bit", sck_out, 1'b1);
        chk("pulses at done", pulses, 8);
        chk("irq", irq, 1'b1);
        chk("rx full", stat.rx_full, 1'b1);
        chk("sent byte", ssp_link_model_inst.rx_word[7:0], 8'h3c);
        repeat (12) @(posedge i_clk);
        chk("pulse total", pulses, 8);
        done_en <= 1'b0;
        #1 chk("masked irq", irq, 1'b0);
        rd_buf("rx byte", 16'h00a5, 16'h00ff);
        clr_done();
        $display("test master byte finished");
        cfg(12'h69c);
        cfg(12'he9c);
        ssp_link_model_inst.tx_word = 32'h1234abcd;
        wr_buf(16'hbeef);
        repeat (6) @(posedge i_clk);
        wr_buf(16'h0f0f);
        wait_sig(1'b1);
        chk("overflow", stat.rx_overflow, 1'b1);
        chk("both words", ssp_link_model_inst.rx_word, 32'hbeef0f0f);
        rd_buf("kept word", 16'h1234, 16'hffff);
        #1 chk("overflow cleared", stat.rx_overflow, 1'b0);
        clr_done();
        $display("test master overflow finished");
        cfg(12'h1c0);
        cfg(12'h9c0);
        ssp_link_model_inst.tx_word = 32'h96000000;
        wr_buf(16'h005a);
        ssp_link_model_inst.frame(8, 6);
        chk("slave done", done, 1'b1);
        chk("slave sent", ssp_link_model_inst.rx_word[7:0], 8'h5a);
        rd_buf("slave byte", 16'h0096, 16'h00ff);
        clr_done();
        cfg(12'h9e0);
        ssp_link_model_inst.tx_word = 32'hff000000;
        ssp_link_model_inst.frame(3, 6);
        chk("output released", sdo_oe_n, 1'b1);
        chk("partial done", done, 1'b0);
        ssp_link_model_inst.tx_word = 32'h3c000000;
        ssp_link_model_inst.frame(8, 6);
        chk("restart done", done, 1'b1);
        rd_buf("restart byte", 16'h003c, 16'h00ff);
        $display("test slave select finished");
        clr_done();
        // Master with idle-high clock, primary /4 and secondary /2
        cfg(12'hd96);
        ssp_link_model_inst.tx_word = 32'h69000000;
        pulses = 0;
        wr_buf(16'h00c3);
        wait_sig(1'b0);
        chk("idle high active", sck_out, 1'b0);
        chk("pulses high idle", pulses, 7);
        idle_wait(half);
        chk("half period", half, 8);
        chk("sent high idle", ssp_link_model_inst.rx_word[7:0], 8'hc3);
        rd_buf("rx high idle", 16'h0069, 16'h00ff);
        $display("test master idle high finished");
        complete_run();
    end
endmodule
